/* dv/lii_host_model.sv */
`timescale 1ns/1ps
// Host side of the register port
module lii_host_model (
   input  wire logic       clk_sys,
   output      logic       reg_chan,
   output      logic [7:0] reg_addr,
   output      logic       reg_wr,
   output      logic       reg_rd,
   output      logic [7:0] reg_wdata
);
   // Idle bus at time zero
   initial
   begin
      reg_chan  = 1'b0;
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end

   // One access; address and data scrambled once released
   task automatic acc(input logic w, input logic ch,
                      input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= w;
      reg_rd    <= ~w;
      reg_chan  <= ch;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule

/* dv/line_interface_interrupt_status_tb.sv */
`timescale 1ns/1ps
`include "lii_map.svh"
module line_interface_interrupt_status_tb;
   logic            clk_sys;
   logic            rst_b;
   logic            clk_en;
   logic            gci_mode;
   logic [1:0][7:0] evt_timer;
   logic [1:0][7:0] evt_line;
   logic [1:0][7:0] evt_alarm;
   logic [2:0]      clk_fail_evt;
   logic            reg_chan;
   logic [7:0]      reg_addr;
   logic            reg_wr;
   logic            reg_rd;
   logic [7:0]      reg_wdata;
   logic [7:0]      reg_rdata;
   logic [7:0]      interrupt_summary;
   logic            irq;
   logic [7:0]      st [2][3];
   logic [7:0]      en [2][3];
   logic [2:0]      cause;
   logic [7:0]      exp_q [$];
   logic            rd_seen = 1'b0;
   int              errors = 0;
   int              samples_checked = 0;

   lii_top lii_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
      .gci_mode(gci_mode), .reg_chan(reg_chan), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .evt_timer(evt_timer), .evt_line(evt_line),
      .evt_alarm(evt_alarm), .clk_fail_evt(clk_fail_evt),
      .interrupt_summary(interrupt_summary), .irq(irq));
   lii_host_model lii_host_model_i (.clk_sys(clk_sys),
      .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata));

   // 100 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input string n, input logic [7:0] e,
                        input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %0s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   function automatic logic [7:0] msk(input int i);
      return i == 0 ? `LII_STAT1_MASK
           : i == 1 ? `LII_STAT2_MASK : `LII_STAT3_MASK;
   endfunction

   function automatic logic [7:0] sum_exp();
      logic [7:0] s;
      s = {|cause, 7'h00};
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 3; i++)
            s[c*4+i] = |(st[c][i] & en[c][i]);
      return s;
   endfunction

   task automatic zero_model();
      cause = 3'h0;
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 3; i++)
         begin
            st[c][i] = 8'h00;
            en[c][i] = 8'h00;
         end
   endtask

   // Read: note expected value, then clear-on-read outside GCI mode
   task automatic rd(input logic ch, input logic [7:0] a);
      logic [7:0] e;
      e = 8'h00;
      if (a == `LII_ADDR_SUMMARY) e = sum_exp();
      else if (a == `LII_ADDR_MSTAT) e = {cause, 5'h00};
      else if (a >= 8'h0F && a <= 8'h11) e = st[ch][a-8'h0F];
      else if (a >= 8'h12 && a <= 8'h14) e = en[ch][a-8'h12];
      exp_q.push_back(e);
      lii_host_model_i.acc(1'b0, ch, a, 8'h00);
      if (!gci_mode && a >= 8'h0F && a <= 8'h11) st[ch][a-8'h0F] = 8'h00;
   endtask

   task automatic wr(input logic ch, input logic [7:0] a,
                     input logic [7:0] d);
      lii_host_model_i.acc(1'b1, ch, a, d);
      if (a >= 8'h12 && a <= 8'h14) en[ch][a-8'h12] = d & msk(a - 8'h12);
      else if (gci_mode && a >= 8'h0F && a <= 8'h11)
         st[ch][a-8'h0F] = d & msk(a - 8'h0F);
      else if (a == `LII_ADDR_MSTAT) cause = cause & ~d[7:5];
   endtask

   task automatic rdall(input logic ch);
      for (int a = 8'h0E; a <= 8'h14; a++)
         rd(ch, 8'(a));
      rd(ch, `LII_ADDR_MSTAT);
      rd(ch, 8'h20);
   endtask

   // one-cycle event pulse, flag kept afterwards
   task automatic ev(input logic ch, input int i, input logic [7:0] d,
                     input logic [2:0] cf);
      @(posedge clk_sys);
      case (i)
         0: evt_timer[ch] <= d;
         1: evt_line[ch] <= d;
         default: evt_alarm[ch] <= d;
      endcase
      clk_fail_evt <= cf;
      @(posedge clk_sys);
      evt_timer    <= '0;
      evt_line     <= '0;
      evt_alarm    <= '0;
      clk_fail_evt <= 3'h0;
      // Events sampled with clk_en low are lost
      if (clk_en)
      begin
         st[ch][i] = st[ch][i] | (d & msk(i));
         cause     = cause | cf;
      end
      @(negedge clk_sys);
      check("summary", sum_exp(), interrupt_summary);
      check("irq", {7'h00, |sum_exp()}, {7'h00, irq});
   endtask

   // Read data checked one cycle after each taken read
   always @(posedge clk_sys)
   begin
      if (rd_seen) check("rdata", exp_q.pop_front(), reg_rdata);
      rd_seen <= reg_rd && clk_en;
   end

   // Watchdog well beyond the expected few hundred cycles
   initial
   begin
      #200_000;
      errors++;
      tally_and_finish();
   end

   initial
   begin
      rst_b        = 1'b1;
      clk_en       = 1'b1;
      gci_mode     = 1'b0;
      evt_timer    = '0;
      evt_line     = '0;
      evt_alarm    = '0;
      clk_fail_evt = 3'h0;
      zero_model();
      void'($urandom(38));
      // Reset edge after time zero so the design sees it
      #1 rst_b = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdall(1'b0);
      rdall(1'b1);
      $display("test reset done");
      // random enables, events and status writes
      for (int r = 0; r < 8; r++)
      begin
         @(posedge clk_sys);
         gci_mode <= r[0];
         for (int c = 0; c < 2; c++)
         begin
            for (int k = 0; k < 3; k++)
               wr(c[0], 8'h12 + 8'(k), 8'($urandom));
            ev(c[0], $urandom_range(2), 8'($urandom), 3'($urandom));
            wr(c[0], 8'h0F + 8'($urandom_range(2)), 8'($urandom));
            wr(c[0], `LII_ADDR_SUMMARY, 8'hFF);
         end
         rdall(1'b0);
         rdall(1'b1);
         wr(1'b0, `LII_ADDR_MSTAT, 8'($urandom));
      end
      $display("test random done");
      // events while clk_en is low are lost
      gci_mode <= 1'b1;
      wr(1'b0, `LII_ADDR_EN2, 8'h3F);
      wr(1'b0, `LII_ADDR_STAT2, 8'h00);
      wr(1'b0, `LII_ADDR_MSTAT, 8'hE0);
      clk_en <= 1'b0;
      ev(1'b0, 1, 8'h3F, 3'h7);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      rdall(1'b0);
      $display("test clock enable done");
      @(posedge clk_sys);
      rst_b <= 1'b0;
      @(posedge clk_sys);
      rst_b <= 1'b1;
      zero_model();
      rdall(1'b0);
      rdall(1'b1);
      $display("test second reset done");
      // Let the last read check retire
      repeat (3) @(posedge clk_sys);
      check("queue", 8'h00, 8'(exp_q.size()));
      tally_and_finish();
   end
endmodule

/* inc/lii_map.svh */
`ifndef LII_MAP_SVH
`define LII_MAP_SVH

// Register offsets
`define LII_ADDR_SUMMARY   8'h0E
`define LII_ADDR_STAT1     8'h0F
`define LII_ADDR_STAT2     8'h10
`define LII_ADDR_STAT3     8'h11
`define LII_ADDR_EN1       8'h12
`define LII_ADDR_EN2       8'h13
`define LII_ADDR_EN3       8'h14
`define LII_ADDR_MSTAT     8'h03

// Implemented bit masks
`define LII_STAT1_MASK     8'hF0
`define LII_STAT2_MASK     8'h3F
`define LII_STAT3_MASK     8'hBF

// Summary field positions
`define LII_SUM_A_LSB      0
`define LII_SUM_RSVD       3
`define LII_SUM_B_LSB      4
`define LII_SUM_CLK        7
`define LII_MSTAT_CAUSE_LSB 5

// Reset values
`define LII_SUMMARY_RST    8'h00
`define LII_STAT_RST       8'h00
`define LII_EN_RST         8'h00
`define LII_CAUSE_RST      3'h0

`endif

/* inc/lii_pkg.sv */
package lii_pkg;

   // Per-channel state: status and enable bytes 1..3
   typedef struct packed {
      logic [2:0][7:0] stat;
      logic [2:0][7:0] en;
   } lii_chan_st_t;

   // Shared state: clock-failure causes and read data
   typedef struct packed {
      logic [2:0] cause;
      logic [7:0] rdata;
   } lii_top_st_t;

endpackage

/* rtl/lii_chan.sv */
`timescale 1ns/1ps
`include "lii_map.svh"

module lii_chan (
   input  wire logic            clk_sys,
   input  wire logic            rst_b,
   input  wire logic            clk_en,
   input  wire logic            gci_mode,
   input  wire logic            sel,
   input  wire logic [7:0]      reg_addr,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic [2:0][7:0] evt,
   output      logic [2:0][7:0] stat,
   output      logic [2:0][7:0] en,
   output      logic [2:0]      pend
);

   localparam logic [2:0][7:0] MASK  = {`LII_STAT3_MASK, `LII_STAT2_MASK,
                                        `LII_STAT1_MASK};
   localparam logic [2:0][7:0] SADDR = {`LII_ADDR_STAT3, `LII_ADDR_STAT2,
                                        `LII_ADDR_STAT1};
   localparam logic [2:0][7:0] EADDR = {`LII_ADDR_EN3, `LII_ADDR_EN2,
                                        `LII_ADDR_EN1};

   lii_pkg::lii_chan_st_t st_r;
   lii_pkg::lii_chan_st_t st_nxt;

   // Next state of status and enable bytes
   always_comb
   begin
      st_nxt = st_r;
      for (int k = 0; k < 3; k++)
      begin
         if (sel && reg_wr && reg_addr == EADDR[k])
         begin
            st_nxt.en[k] = reg_wdata & MASK[k];
         end
         if (sel && reg_wr && gci_mode && reg_addr == SADDR[k])
         begin
            st_nxt.stat[k] = reg_wdata & MASK[k];
         end
         else if (sel && reg_rd && !gci_mode && reg_addr == SADDR[k])
         begin
            st_nxt.stat[k] = `LII_STAT_RST;
         end
         st_nxt.stat[k] = st_nxt.stat[k] | (evt[k] & MASK[k]);
      end
   end

   // State register, frozen while clk_en low
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= {{3{`LII_STAT_RST}}, {3{`LII_EN_RST}}};
      end
      else if (clk_en)
      begin
         st_r <= st_nxt;
      end
   end

   assign stat = st_r.stat;
   assign en   = st_r.en;

   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         pend[k] = |(st_r.stat[k] & st_r.en[k]);
      end
   end

   sequence wr_en3;
      clk_en && sel && reg_wr && reg_addr == `LII_ADDR_EN3;
   endsequence

   AST_EVT_LATCHED: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      clk_en |=> ((st_r.stat & $past(evt)) == ($past(evt) & MASK)))
      else $error("event not latched into status");

   AST_RO_NO_GCI: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (clk_en && !gci_mode && evt == '0)
      |=> ((st_r.stat & ~$past(st_r.stat)) == '0))
      else $error("status bit set without event outside GCI mode");

   AST_RSVD_ZERO: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ((st_r.stat & ~MASK) == '0) && ((st_r.en & ~MASK) == '0))
      else $error("reserved bit reads as one");

   AST_MASKED: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (st_r.en[1] == '0) |-> !pend[1])
      else $error("masked source raised pending");

   AST_EN3_WRITE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_en3 |=> (st_r.en[2] == ($past(reg_wdata) & `LII_STAT3_MASK)))
      else $error("third enable byte not written");

endmodule

/* rtl/lii_top.sv */
`timescale 1ns/1ps
`include "lii_map.svh"

// Behaviour
// - One shared summary register, resets to zero
// - Summary shows which channel byte is pending
// - D2..D0 flag channel A bytes 3..1
// - D6..D4 flag channel B; D3 reads zero
// - D7 clock failure; cause in master bits 7:5
// - Status byte 1 timer flags; 3:0 zero
// - Status byte 2 line flags; 7:6 zero
// - Status byte 3 balance, alarms; D6 zero
// - Status bytes writable only in GCI mode
// - Enable bit zero masks, one allows
// - Enable byte 1 timer enables; 3:0 zero
// - Enable byte 2 line enables; 7:6 zero
// - Enable byte 3 masks status byte 3
// - Flags hold event history until serviced

module lii_top (
   input  wire logic            clk_sys,
   input  wire logic            rst_b,
   input  wire logic            clk_en,
   input  wire logic            gci_mode,
   input  wire logic            reg_chan,
   input  wire logic [7:0]      reg_addr,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [7:0]      reg_wdata,
   output      logic [7:0]      reg_rdata,
   input  wire logic [1:0][7:0] evt_timer,
   input  wire logic [1:0][7:0] evt_line,
   input  wire logic [1:0][7:0] evt_alarm,
   input  wire logic [2:0]      clk_fail_evt,
   output      logic [7:0]      interrupt_summary,
   output      logic            irq
);

   lii_pkg::lii_top_st_t st_r;
   lii_pkg::lii_top_st_t st_nxt;

   logic [1:0][2:0][7:0] ch_stat;
   logic [1:0][2:0][7:0] ch_en;
   logic [1:0][2:0]      ch_pend;
   logic                 clock_fail_pending;
   logic [2:0]           chan_a_pending;
   logic [2:0]           chan_b_pending;
   logic [7:0]           master_status;
   logic [2:0][7:0]      sel_stat;
   logic [2:0][7:0]      sel_en;

   // Both line channels, index 0 is channel A
   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_chan
         lii_chan u_chan (
            .clk_sys   (clk_sys),
            .rst_b     (rst_b),
            .clk_en    (clk_en),
            .gci_mode  (gci_mode),
            .sel       (reg_chan == 1'(c)),
            .reg_addr  (reg_addr),
            .reg_wr    (reg_wr),
            .reg_rd    (reg_rd),
            .reg_wdata (reg_wdata),
            .evt       ({evt_alarm[c], evt_line[c], evt_timer[c]}),
            .stat      (ch_stat[c]),
            .en        (ch_en[c]),
            .pend      (ch_pend[c])
         );
      end
   endgenerate

   // Pending flags per channel byte
   assign chan_a_pending     = ch_pend[0];
   assign chan_b_pending     = ch_pend[1];
   assign clock_fail_pending = |st_r.cause;

   assign master_status = {st_r.cause, 5'h00};

   // single shared summary, zero from reset
   // channel B in high bits, D3 zero
   always_comb
   begin
      interrupt_summary = `LII_SUMMARY_RST;
      interrupt_summary[`LII_SUM_A_LSB +: 3] = chan_a_pending;
      interrupt_summary[`LII_SUM_B_LSB +: 3] = chan_b_pending;
      interrupt_summary[`LII_SUM_RSVD]       = 1'b0;
      interrupt_summary[`LII_SUM_CLK]        = clock_fail_pending;
   end

   // level interrupt on any enabled flag
   assign irq = |interrupt_summary;

   // Channel picked by the register access
   assign sel_stat = ch_stat[reg_chan];
   assign sel_en   = ch_en[reg_chan];

   // Clock-failure causes and registered read data
   always_comb
   begin
      st_nxt = st_r;
      // Write-one clears a cause, new failure wins
      if (reg_wr && reg_addr == `LII_ADDR_MSTAT)
      begin
         st_nxt.cause = st_r.cause &
                        ~reg_wdata[`LII_MSTAT_CAUSE_LSB +: 3];
      end
      st_nxt.cause = st_nxt.cause | clk_fail_evt;
      if (reg_rd)
      begin
         if (reg_addr == `LII_ADDR_SUMMARY)
         begin
            st_nxt.rdata = interrupt_summary;
         end
         else if (reg_addr == `LII_ADDR_MSTAT)
         begin
            st_nxt.rdata = master_status;
         end
         else if (reg_addr == `LII_ADDR_STAT1)
         begin
            st_nxt.rdata = sel_stat[0];
         end
         else if (reg_addr == `LII_ADDR_STAT2)
         begin
            st_nxt.rdata = sel_stat[1];
         end
         else if (reg_addr == `LII_ADDR_STAT3)
         begin
            st_nxt.rdata = sel_stat[2];
         end
         else if (reg_addr == `LII_ADDR_EN1)
         begin
            st_nxt.rdata = sel_en[0];
         end
         else if (reg_addr == `LII_ADDR_EN2)
         begin
            st_nxt.rdata = sel_en[1];
         end
         else if (reg_addr == `LII_ADDR_EN3)
         begin
            st_nxt.rdata = sel_en[2];
         end
         else
         begin
            st_nxt.rdata = 8'h00; // Unmapped reads zero
         end
      end
   end

   // State register, frozen while clk_en low
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= {`LII_CAUSE_RST, 8'h00};
      end
      else if (clk_en)
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;

   sequence rd_summary;
      clk_en && reg_rd && reg_addr == `LII_ADDR_SUMMARY;
   endsequence

   sequence clk_fail_hit;
      clk_en && clk_fail_evt != 3'h0;
   endsequence

   AST_SUM_RESET: assert property (@(posedge clk_sys)
      !rst_b |-> interrupt_summary == `LII_SUMMARY_RST)
      else $error("summary not zero in reset");

   AST_SUM_READ: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      rd_summary |=> reg_rdata == $past(interrupt_summary))
      else $error("summary read returned wrong value");

   AST_SUM_MAP: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      interrupt_summary[6:4] == {|(ch_stat[1][2] & ch_en[1][2]),
                                 |(ch_stat[1][1] & ch_en[1][1]),
                                 |(ch_stat[1][0] & ch_en[1][0])}
      && interrupt_summary[2:0] == {|(ch_stat[0][2] & ch_en[0][2]),
                                    |(ch_stat[0][1] & ch_en[0][1]),
                                    |(ch_stat[0][0] & ch_en[0][0])}
      && !interrupt_summary[3])
      else $error("summary bit does not match channel bytes");

   AST_CLK_FAIL: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      clk_fail_hit |=> interrupt_summary[7]
      && ((master_status[7:5] & $past(clk_fail_evt)) == $past(clk_fail_evt)))
      else $error("clock failure not flagged");

   AST_IRQ_LEVEL: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      irq == (clock_fail_pending || |ch_pend))
      else $error("interrupt output disagrees with pending flags");

endmodule
